// ==== logic/ced_pkg.sv ====
package ced_pkg;
   // APB register map (word aligned byte addresses)
   localparam int APB_ADDR_W = 12;
   localparam int APB_DATA_W = 32;
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_ACCUM = 12'h004;
   localparam logic [11:0] OFS_FLAGS = 12'h008;
   localparam logic [11:0] OFS_BANK = 12'h00C;
   localparam logic [11:0] OFS_PTR0 = 12'h010;
   localparam logic [11:0] OFS_PTR1 = 12'h014;
   localparam logic [11:0] OFS_PTR2 = 12'h018;
   localparam logic [11:0] OFS_LATCH = 12'h01C;
   localparam logic [11:0] OFS_INFO = 12'h020;

   // Field positions
   localparam int CTRL_EXT_BIT = 0;
   localparam int CTRL_RUN_BIT = 1;
   localparam int FLAG_Z_BIT = 0;
   localparam int FLAG_N_BIT = 1;
   localparam int LATCH_UPPER_LSB = 8;

   // Reset values
   localparam logic CTRL_EXT_RESET = 1'b0;
   localparam logic CTRL_RUN_RESET = 1'b0;
   localparam logic [7:0] ACCUM_RESET = 8'h00;
   localparam logic [1:0] FLAGS_RESET = 2'h0;
   localparam logic [3:0] BANK_RESET = 4'h0;
   localparam logic [11:0] PTR_RESET = 12'h000;
   localparam logic [7:0] LATCH_HIGH_RESET = 8'h00;
   localparam logic [4:0] LATCH_UPPER_RESET = 5'h00;

   // Widths
   localparam int PC_W = 21;
   localparam int DADDR_W = 12;

   // Opcode patterns
   localparam logic [6:0] OPC_TEST_ZERO_SKIP = 7'b0110_011;
   localparam logic [7:0] OPC_XOR_LITERAL_ACCUM = 8'h0A;
   localparam logic [5:0] OPC_XOR_ACCUM_REGISTER = 6'b0001_10;
   localparam logic [7:0] OPC_POINTER_ADD = 8'hE8;
   localparam logic [7:0] OPC_POINTER_SUB = 8'hE9;
   localparam logic [7:0] OPC_PUSH_LITERAL = 8'hEA;
   localparam logic [7:0] OPC_MOVE_INDEXED = 8'hEB;
   localparam logic [15:0] OPC_CALL_VIA_ACCUM = 16'h0014;
   localparam logic [3:0] OPC_SECOND_WORD = 4'hF;
   localparam logic [1:0] SEL_FRAME = 2'b11;
   localparam logic [7:0] ACCESS_SPLIT = 8'h5F;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic [20:0] RETURN_STEP = 21'h000002;

   // Other two-word base opcodes, used only to size a skip
   localparam logic [3:0] OPC2_MOVE_FF = 4'hC;
   localparam logic [6:0] OPC2_CALL = 7'b1110_110;
   localparam logic [7:0] OPC2_LOAD_PTR = 8'hEE;
   localparam logic [7:0] OPC2_GOTO = 8'hEF;

   // Indirect addressing register window (source reads return zero)
   localparam logic [11:0] INDIRECT_FIRST = 12'hFE0;
   localparam logic [11:0] INDIRECT_LAST = 12'hFFF;
   localparam logic [7:0] INDIRECT_VALUE = 8'h00;

   // Quarter phases
   localparam logic [1:0] PHASE_Q1 = 2'd0;
   localparam logic [1:0] PHASE_Q2 = 2'd1;
   localparam logic [1:0] PHASE_Q3 = 2'd2;
   localparam logic [1:0] PHASE_Q4 = 2'd3;

   typedef enum logic [1:0] {
      CED_EXEC = 2'b00,
      CED_FLUSH = 2'b01,
      CED_SECOND = 2'b10
   } ced_state_type;

   typedef enum logic [3:0] {
      CED_OP_NONE = 4'b0000,
      CED_OP_TEST = 4'b0001,
      CED_OP_XORLIT = 4'b0010,
      CED_OP_XORREG = 4'b0011,
      CED_OP_PADD = 4'b0100,
      CED_OP_PSUB = 4'b0101,
      CED_OP_CALLACC = 4'b0110,
      CED_OP_MOVE = 4'b0111,
      CED_OP_PUSH = 4'b1000
   } ced_op_type;
endpackage : ced_pkg

// ==== logic/ced_qphase.sv ====
`timescale 1ns/100ps
module ced_qphase
   import ced_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic run,
   output logic [1:0] qPhase
);
   logic [1:0] next_qPhase;

   // Stopping abandons the current instruction cycle and restarts at Q1
   always_comb
   begin
      next_qPhase = run ? qPhase + 2'd1 : PHASE_Q1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         qPhase <= PHASE_Q1;
      else
         qPhase <= next_qPhase;
   end
endmodule : ced_qphase

// ==== logic/cpu_ext_instruction_decode.sv ====
// Notes on behaviour
// - zero register skips next instruction, flags kept
// - skipped two-word instruction costs two flush cycles
// - access bit 0 access bank, 1 bank pointer
// - extended, access, operand <=5Fh means frame indexed
// - literal xor into accumulator, N and Z
// - register xor, destination bit picks target, N Z
// - extensions off unless CTRL ext bit set
// - eight extra opcodes decoded only when enabled
// - selector 11 adds to frame, then returns
// - pointer subtract six-bit literal, one cycle
// - selector 11 subtracts from frame, then returns
// - accumulator call, two cycles, flags kept
// - indexed to register move, two words
// - indexed to indexed move, two words
// - push literal at frame, decrement frame pointer
// - call pushes pc+2, loads latches and accumulator
// - indirect source address moves value zero
// - literal unsigned, added to full pointer
`timescale 1ns/100ps
module cpu_ext_instruction_decode
   import ced_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_ADDR_W-1:0] paddr,
   input wire logic [APB_DATA_W-1:0] pwdata,
   output logic [APB_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] instrWord,
   input wire logic [PC_W-1:0] pcCurrent,
   input wire logic [PC_W-1:0] returnStackTop,
   input wire logic [7:0] regReadData,
   output logic [DADDR_W-1:0] regAddr,
   output logic regReadStrobe,
   output logic regWriteStrobe,
   output logic [7:0] regWriteData,
   output logic pcLoad,
   output logic [PC_W-1:0] pcLoadValue,
   output logic stackPush,
   output logic [PC_W-1:0] stackPushValue,
   output logic stackPop,
   output logic discardPrefetch,
   output logic cycleDone
);
   logic [1:0] qPhase;
   logic ctrlExt, ctrlRun;
   logic [7:0] accum;
   logic [1:0] flags;
   logic [3:0] bank;
   logic [11:0] ptr [3];
   logic [7:0] latchHigh;
   logic [4:0] latchUpper;
   ced_state_type state;
   logic flushChain, skipTaken, moveToIndexed;
   logic [15:0] ir;
   logic [7:0] result, srcData;

   logic next_ctrlExt, next_ctrlRun;
   logic [7:0] next_accum;
   logic [1:0] next_flags;
   logic [3:0] next_bank;
   logic [11:0] next_ptr [3];
   logic [7:0] next_latchHigh;
   logic [4:0] next_latchUpper;
   ced_state_type next_state;
   logic next_flushChain, next_skipTaken, next_moveToIndexed;
   logic [15:0] next_ir;
   logic [7:0] next_result, next_srcData;
   logic [DADDR_W-1:0] next_regAddr;
   logic next_regReadStrobe, next_regWriteStrobe;
   logic [7:0] next_regWriteData;
   logic next_pcLoad, next_stackPush, next_stackPop, next_discardPrefetch, next_cycleDone;
   logic [PC_W-1:0] next_pcLoadValue, next_stackPushValue;
   logic [APB_DATA_W-1:0] next_prdata;
   logic next_pready, next_pslverr;

   logic apbAccess, apbWrite;
   ced_op_type op;
   logic [11:0] byteAddr;
   logic [1:0] ptrSel;

   ced_qphase u_qphase
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .run(ctrlRun),
      .qPhase(qPhase)
   );

   function automatic logic regHit(input logic [APB_ADDR_W-1:0] a);
      return a == OFS_CTRL || a == OFS_ACCUM || a == OFS_FLAGS || a == OFS_BANK || a == OFS_PTR0
         || a == OFS_PTR1 || a == OFS_PTR2 || a == OFS_LATCH || a == OFS_INFO;
   endfunction : regHit

   function automatic ced_op_type decodeOp(input logic [15:0] w, input logic ext);
      ced_op_type o;
      o = CED_OP_NONE;
      if (w[15:9] == OPC_TEST_ZERO_SKIP)
         o = CED_OP_TEST;
      else if (w[15:8] == OPC_XOR_LITERAL_ACCUM)
         o = CED_OP_XORLIT;
      else if (w[15:10] == OPC_XOR_ACCUM_REGISTER)
         o = CED_OP_XORREG;
      else if (ext)
      begin
         // Extension opcodes exist only while enabled
         if (w[15:8] == OPC_POINTER_ADD)
            o = CED_OP_PADD;
         else if (w[15:8] == OPC_POINTER_SUB)
            o = CED_OP_PSUB;
         else if (w[15:8] == OPC_PUSH_LITERAL)
            o = CED_OP_PUSH;
         else if (w[15:8] == OPC_MOVE_INDEXED)
            o = CED_OP_MOVE;
         else if (w == OPC_CALL_VIA_ACCUM)
            o = CED_OP_CALLACC;
      end
      return o;
   endfunction : decodeOp

   function automatic logic isTwoWord(input logic [15:0] w, input logic ext);
      return w[15:12] == OPC2_MOVE_FF || w[15:9] == OPC2_CALL || w[15:8] == OPC2_LOAD_PTR
         || w[15:8] == OPC2_GOTO || (ext && w[15:8] == OPC_MOVE_INDEXED);
   endfunction : isTwoWord

   function automatic logic [11:0] fileAddr(input logic [7:0] f, input logic a, input logic [3:0] b,
                                            input logic [11:0] frame, input logic ext);
      if (a)
         return {b, f};
      else if (ext && f <= ACCESS_SPLIT)
         return frame + {4'h0, f};
      else if (f <= ACCESS_SPLIT)
         return {4'h0, f};
      else
         return {ACCESS_HIGH_BANK, f};
   endfunction : fileAddr

   // APB handshake: one wait state, answer registered
   assign apbAccess = psel & penable & ~pready;
   assign apbWrite = psel & penable & pready & pwrite & ~pslverr;

   always_comb
   begin
      next_pready = apbAccess;
      next_pslverr = apbAccess & ~regHit(paddr);
      next_prdata = 32'h0000_0000;
      if (apbAccess && !pwrite)
      begin
         case (paddr)
            OFS_CTRL: next_prdata = {30'h0, ctrlRun, ctrlExt};
            OFS_ACCUM: next_prdata = {24'h0, accum};
            OFS_FLAGS: next_prdata = {30'h0, flags};
            OFS_BANK: next_prdata = {28'h0, bank};
            OFS_PTR0: next_prdata = {20'h0, ptr[0]};
            OFS_PTR1: next_prdata = {20'h0, ptr[1]};
            OFS_PTR2: next_prdata = {20'h0, ptr[2]};
            OFS_LATCH: next_prdata = {19'h0, latchUpper, latchHigh};
            OFS_INFO: next_prdata = {22'h0, flushChain, skipTaken, state, op, qPhase};
            default: next_prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
      end
   end

   assign op = decodeOp(ir, ctrlExt);
   assign byteAddr = fileAddr(ir[7:0], ir[8], bank, ptr[2], ctrlExt);
   assign ptrSel = (ir[7:6] == SEL_FRAME) ? 2'd2 : ir[7:6];

   always_comb
   begin
      next_ctrlExt = ctrlExt;
      next_ctrlRun = ctrlRun;
      next_accum = accum;
      next_flags = flags;
      next_bank = bank;
      next_ptr = ptr;
      next_latchHigh = latchHigh;
      next_latchUpper = latchUpper;
      next_state = state;
      next_flushChain = flushChain;
      next_skipTaken = skipTaken;
      next_moveToIndexed = moveToIndexed;
      next_ir = ir;
      next_result = result;
      next_srcData = srcData;
      next_regAddr = regAddr;
      next_regReadStrobe = 1'b0;
      next_regWriteStrobe = 1'b0;
      next_regWriteData = regWriteData;
      next_pcLoad = 1'b0;
      next_pcLoadValue = pcLoadValue;
      next_stackPush = 1'b0;
      next_stackPushValue = stackPushValue;
      next_stackPop = 1'b0;
      next_cycleDone = 1'b0;
      if (ctrlRun)
      begin
         case (qPhase)
            PHASE_Q1: next_ir = instrWord;
            PHASE_Q2:
            begin
               if (state == CED_EXEC && (op == CED_OP_TEST || op == CED_OP_XORREG))
               begin
                  next_regAddr = byteAddr;
                  next_regReadStrobe = 1'b1;
               end
               else if (state == CED_EXEC && op == CED_OP_MOVE)
               begin
                  next_regAddr = ptr[2] + {5'h00, ir[6:0]};
                  next_regReadStrobe = 1'b1;
               end
            end
            PHASE_Q3:
            begin
               if (state == CED_EXEC)
               begin
                  case (op)
                     CED_OP_TEST: next_skipTaken = (regReadData == 8'h00);
                     CED_OP_XORLIT: next_result = accum ^ ir[7:0];
                     CED_OP_XORREG: next_result = accum ^ regReadData;
                     CED_OP_MOVE:
                     begin
                        next_srcData = (regAddr >= INDIRECT_FIRST && regAddr <= INDIRECT_LAST) ?
                           INDIRECT_VALUE : regReadData;
                        next_moveToIndexed = ir[7];
                     end
                     CED_OP_CALLACC:
                     begin
                        next_stackPush = 1'b1;
                        next_stackPushValue = pcCurrent + RETURN_STEP;
                     end
                     default: next_result = result;
                  endcase
               end
            end
            default:
            begin
               next_cycleDone = 1'b1;
               next_state = CED_EXEC;
               next_flushChain = 1'b0;
               case (state)
                  CED_EXEC:
                  begin
                     case (op)
                        CED_OP_TEST:
                        begin
                           if (skipTaken)
                           begin
                              next_state = CED_FLUSH;
                              next_flushChain = 1'b1;
                           end
                        end
                        CED_OP_XORLIT:
                        begin
                           next_accum = result;
                           next_flags[FLAG_Z_BIT] = (result == 8'h00);
                           next_flags[FLAG_N_BIT] = result[7];
                        end
                        CED_OP_XORREG:
                        begin
                           if (ir[9])
                           begin
                              next_regAddr = byteAddr;
                              next_regWriteData = result;
                              next_regWriteStrobe = 1'b1;
                           end
                           else
                              next_accum = result;
                           next_flags[FLAG_Z_BIT] = (result == 8'h00);
                           next_flags[FLAG_N_BIT] = result[7];
                        end
                        CED_OP_PADD, CED_OP_PSUB:
                        begin
                           if (op == CED_OP_PADD)
                              next_ptr[ptrSel] = ptr[ptrSel] + {6'h00, ir[5:0]};
                           else
                              next_ptr[ptrSel] = ptr[ptrSel] - {6'h00, ir[5:0]};
                           if (ir[7:6] == SEL_FRAME)
                           begin
                              next_pcLoad = 1'b1;
                              next_pcLoadValue = returnStackTop;
                              next_stackPop = 1'b1;
                              next_state = CED_FLUSH;
                           end
                        end
                        CED_OP_PUSH:
                        begin
                           next_regAddr = ptr[2];
                           next_regWriteData = ir[7:0];
                           next_regWriteStrobe = 1'b1;
                           next_ptr[2] = ptr[2] - 12'h001;
                        end
                        CED_OP_CALLACC:
                        begin
                           next_pcLoad = 1'b1;
                           next_pcLoadValue = {latchUpper, latchHigh, accum};
                           next_state = CED_FLUSH;
                        end
                        CED_OP_MOVE: next_state = CED_SECOND;
                        default: next_state = CED_EXEC;
                     endcase
                  end
                  CED_SECOND:
                  begin
                     next_regAddr = moveToIndexed ? ptr[2] + {5'h00, ir[6:0]} : ir[11:0];
                     next_regWriteData = srcData;
                     next_regWriteStrobe = 1'b1;
                  end
                  CED_FLUSH:
                  begin
                     // Nothing from the discarded word takes effect
                     if (flushChain && isTwoWord(ir, ctrlExt))
                        next_state = CED_FLUSH;
                  end
                  default: next_state = CED_EXEC;
               endcase
            end
         endcase
      end
      else
      begin
         // Stopping mid-instruction drops any pending work
         next_state = CED_EXEC;
         next_flushChain = 1'b0;
      end
      // Software writes win over core updates in the same cycle
      if (apbWrite)
      begin
         case (paddr)
            OFS_CTRL:
            begin
               next_ctrlExt = pwdata[CTRL_EXT_BIT];
               next_ctrlRun = pwdata[CTRL_RUN_BIT];
            end
            OFS_ACCUM: next_accum = pwdata[7:0];
            OFS_FLAGS: next_flags = pwdata[1:0];
            OFS_BANK: next_bank = pwdata[3:0];
            OFS_PTR0: next_ptr[0] = pwdata[11:0];
            OFS_PTR1: next_ptr[1] = pwdata[11:0];
            OFS_PTR2: next_ptr[2] = pwdata[11:0];
            OFS_LATCH:
            begin
               next_latchHigh = pwdata[7:0];
               next_latchUpper = pwdata[LATCH_UPPER_LSB+4:LATCH_UPPER_LSB];
            end
            default: next_bank = bank;
         endcase
      end
      next_discardPrefetch = next_ctrlRun && next_state == CED_FLUSH;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ctrlExt <= CTRL_EXT_RESET;
         ctrlRun <= CTRL_RUN_RESET;
         accum <= ACCUM_RESET;
         flags <= FLAGS_RESET;
         bank <= BANK_RESET;
         ptr <= '{PTR_RESET, PTR_RESET, PTR_RESET};
         latchHigh <= LATCH_HIGH_RESET;
         latchUpper <= LATCH_UPPER_RESET;
         state <= CED_EXEC;
         flushChain <= 1'b0;
         skipTaken <= 1'b0;
         moveToIndexed <= 1'b0;
         ir <= 16'h0000;
         result <= 8'h00;
         srcData <= 8'h00;
         regAddr <= 12'h000;
         regReadStrobe <= 1'b0;
         regWriteStrobe <= 1'b0;
         regWriteData <= 8'h00;
         pcLoad <= 1'b0;
         pcLoadValue <= 21'h000000;
         stackPush <= 1'b0;
         stackPushValue <= 21'h000000;
         stackPop <= 1'b0;
         discardPrefetch <= 1'b0;
         cycleDone <= 1'b0;
      end
      else
      begin
         ctrlExt <= next_ctrlExt;
         ctrlRun <= next_ctrlRun;
         accum <= next_accum;
         flags <= next_flags;
         bank <= next_bank;
         ptr <= next_ptr;
         latchHigh <= next_latchHigh;
         latchUpper <= next_latchUpper;
         state <= next_state;
         flushChain <= next_flushChain;
         skipTaken <= next_skipTaken;
         moveToIndexed <= next_moveToIndexed;
         ir <= next_ir;
         result <= next_result;
         srcData <= next_srcData;
         regAddr <= next_regAddr;
         regReadStrobe <= next_regReadStrobe;
         regWriteStrobe <= next_regWriteStrobe;
         regWriteData <= next_regWriteData;
         pcLoad <= next_pcLoad;
         pcLoadValue <= next_pcLoadValue;
         stackPush <= next_stackPush;
         stackPushValue <= next_stackPushValue;
         stackPop <= next_stackPop;
         discardPrefetch <= next_discardPrefetch;
         cycleDone <= next_cycleDone;
      end
   end
endmodule : cpu_ext_instruction_decode

// ==== verification/ced_mem_model.sv ====
`timescale 1ns/100ps
module ced_mem_model
   import ced_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [DADDR_W-1:0] regAddr,
   input wire logic regReadStrobe,
   input wire logic regWriteStrobe,
   input wire logic [7:0] regWriteData,
   input wire logic pcLoad,
   input wire logic [PC_W-1:0] pcLoadValue,
   input wire logic stackPush,
   input wire logic [PC_W-1:0] stackPushValue,
   input wire logic cycleDone,
   output logic [15:0] instrWord,
   output logic [PC_W-1:0] pcCurrent,
   output logic [PC_W-1:0] returnStackTop,
   output logic [7:0] regReadData
);
   bit [15:0] prog [64];
   bit [7:0] mem [4096];
   logic [5:0] cnt;
   // Next word already shows while cycleDone is high, so either Q1 edge takes it
   assign instrWord = prog[cnt + 6'(cycleDone)];
   assign pcCurrent = PC_W'({cnt, 1'b0});
   // Unselected read bus shows inverted data so a stray sample is caught
   assign regReadData = regReadStrobe ? mem[regAddr] : ~mem[regAddr];
   always @(posedge clk_sys)
   begin
      if (rst)
         cnt <= 6'h00;
      else if (pcLoad)
         cnt <= pcLoadValue[6:1] - 6'h01;
      else if (cycleDone)
         cnt <= cnt + 6'h01;
      if (stackPush)
         returnStackTop <= stackPushValue;
      if (regWriteStrobe)
         mem[regAddr] <= regWriteData;
   end
endmodule : ced_mem_model

// ==== verification/ced_monitor.sv ====
`timescale 1ns/100ps
module ced_monitor
   import ced_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [PC_W-1:0] pcCurrent,
   input wire logic regReadStrobe,
   input wire logic regWriteStrobe,
   input wire logic pcLoad,
   input wire logic stackPush,
   input wire logic [PC_W-1:0] stackPushValue,
   input wire logic stackPop,
   input wire logic discardPrefetch,
   input wire logic cycleDone
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   a_quarter_done: assert property (cycleDone |=> !cycleDone [*3])
      else $error("cycleDone spacing");
   a_one_read: assert property (regReadStrobe |=> !regReadStrobe [*3])
      else $error("extra read");
   a_flush_whole: assert property ($rose(discardPrefetch) |-> discardPrefetch [*4])
      else $error("short flush");
   a_flush_quiet: assert property (discardPrefetch && $past(discardPrefetch)
      |-> !(regWriteStrobe || regReadStrobe)) else $error("flush touched data");
   a_pop_loads: assert property (stackPop |-> pcLoad)
      else $error("pop without load");
   a_load_flush: assert property (pcLoad |-> ##[0:4] discardPrefetch)
      else $error("load without flush");
   a_push_return: assert property (stackPush |-> stackPushValue == pcCurrent + 21'h000002)
      else $error("bad return address");
   c_return: cover property (stackPop);
   c_refused: cover property (pslverr);
   c_long_skip: cover property (discardPrefetch [*8]);
endmodule : ced_monitor
bind cpu_ext_instruction_decode ced_monitor i_monitor (.clk_sys, .rst, .psel, .penable, .pready, .pslverr,
   .pcCurrent, .regReadStrobe, .regWriteStrobe, .pcLoad, .stackPush, .stackPushValue, .stackPop,
   .discardPrefetch, .cycleDone);

// ==== verification/cpu_ext_instruction_decode_tb.sv ====
`timescale 1ns/100ps
module cpu_ext_instruction_decode_tb
   import ced_pkg::*;
;
   logic clk_sys, pready, pslverr, regReadStrobe, regWriteStrobe, pcLoad, stackPush, stackPop, err;
   logic discardPrefetch, cycleDone, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000, regAddr;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [15:0] instrWord;
   logic [20:0] pcCurrent, returnStackTop, pcLoadValue, stackPushValue;
   logic [7:0] regReadData, regWriteData;
   int bad_count, n_compared, flushN, loadN;
   cpu_ext_instruction_decode i_dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .instrWord, .pcCurrent, .returnStackTop, .regReadData, .regAddr, .regReadStrobe,
      .regWriteStrobe, .regWriteData, .pcLoad, .pcLoadValue, .stackPush, .stackPushValue, .stackPop,
      .discardPrefetch, .cycleDone);
   ced_mem_model i_mem (.clk_sys, .rst, .regAddr, .regReadStrobe, .regWriteStrobe, .regWriteData, .pcLoad,
      .pcLoadValue, .stackPush, .stackPushValue, .cycleDone, .instrWord, .pcCurrent, .returnStackTop,
      .regReadData);
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Reads compare against d; one idle clock keeps psel from being set twice in a step
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
         @(posedge clk_sys);
      while (pready !== 1'b1 && n++ < 20);
      // A slave that never answers counts against the run
      if (pready !== 1'b1)
         bad_count++;
      err = pslverr;
      if (!wr)
         chk(prdata, d);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : bus
   // Stops after n cycle boundaries; programs end in no-ops so a late stop is harmless
   task automatic run(input logic ext, input int n);
      bus(1'b1, OFS_CTRL, {30'h0, 1'b1, ext});
      flushN = 0;
      loadN = 0;
      while (n > 0)
      begin
         @(posedge clk_sys);
         n -= int'(cycleDone === 1'b1);
         flushN += int'(discardPrefetch === 1'b1);
         loadN += int'(pcLoad === 1'b1);
      end
      bus(1'b1, OFS_CTRL, {31'h0, ext});
   endtask : run
   task automatic start(input logic [15:0] p [8]);
      @(posedge clk_sys);
      rst <= 1'b1;
      i_mem.mem = '{default: 8'h00};
      i_mem.prog = '{default: 16'h0000};
      foreach (p[i])
         i_mem.prog[i] = p[i];
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
   endtask : start
   task automatic test_base();
      start('{16'hE823, 16'h0AAF, 16'h1B10, 16'h6611, 16'hEF00, 16'hF000, 16'h0A1A, 16'h0000});
      bus(1'b0, OFS_CTRL, 32'h0);
      bus(1'b0, 12'h040, 32'h0);
      chk({31'h0, err}, 32'h1);
      bus(1'b1, OFS_ACCUM, 32'h1B5);
      bus(1'b1, OFS_BANK, 32'h2);
      run(1'b0, 7);
      bus(1'b0, OFS_PTR0, 32'h0);
      bus(1'b0, OFS_ACCUM, 32'h0);
      bus(1'b0, OFS_FLAGS, 32'h1);
      chk(32'(i_mem.mem[12'h210]), 32'h1A);
      chk(32'(flushN), 32'h8);
      chk(32'(loadN), 32'h0);
      $display("test_base done");
   endtask : test_base
   task automatic test_ext();
      start('{16'hE823, 16'hE945, 16'hEA5A, 16'h1801, 16'hEB01, 16'hF123, 16'h0014, 16'h0A0F});
      i_mem.prog[37] = 16'hE8C2;
      bus(1'b1, OFS_ACCUM, 32'h10);
      bus(1'b1, OFS_PTR0, 32'h3FF);
      bus(1'b1, OFS_PTR2, 32'h080);
      run(1'b1, 11);
      bus(1'b0, OFS_PTR0, 32'h422);
      bus(1'b0, OFS_PTR1, 32'hFFB);
      bus(1'b0, OFS_PTR2, 32'h081);
      bus(1'b0, OFS_ACCUM, 32'h45);
      chk(32'(i_mem.mem[12'h080]), 32'h5A);
      chk(32'(i_mem.mem[12'h123]), 32'h5A);
      chk(32'(returnStackTop), 32'h00E);
      chk(32'(loadN), 32'h2);
      chk(32'(flushN), 32'h8);
      $display("test_ext done");
   endtask : test_ext
   task automatic test_more();
      // Return target is the 0Eh left on the stack by the call in test_ext
      start('{16'hEB01, 16'hF011, 16'hEBA5, 16'hF030, 16'hE9C3, 16'h0AFF, 16'h0AFF, 16'h0A3C});
      i_mem.mem[12'hFE1] = 8'h77;
      i_mem.mem[12'h011] = 8'h55;
      i_mem.mem[12'h005] = 8'h66;
      bus(1'b1, OFS_PTR2, 32'hFE0);
      run(1'b1, 7);
      bus(1'b0, OFS_PTR2, 32'hFDD);
      bus(1'b0, OFS_ACCUM, 32'h3C);
      chk(32'(i_mem.mem[12'h011]), 32'h0);
      chk(32'(i_mem.mem[12'h010]), 32'h66);
      chk(32'(loadN), 32'h1);
      chk(32'(flushN), 32'h4);
      $display("test_more done");
   endtask : test_more
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   initial
   begin
      test_base();
      test_ext();
      test_more();
      end_sim();
   end
   initial
   begin
      #20000;
      bad_count++;
      end_sim();
   end
endmodule : cpu_ext_instruction_decode_tb
